//--- rtl/bts_map.svh
`ifndef BTS_MAP_SVH
`define BTS_MAP_SVH
// ****************************************
// bus geometry (8/4/2, 9/9/1, 18/9/2 or 36/9/4)
// ****************************************
`define BTS_DATA_W 18
`define BTS_LANE_W 9
`define BTS_LANES 2
`define BTS_ADDR_W 8
// ****************************************
// burst and timing
// ****************************************
`define BTS_BURST 2'h2
`define BTS_BURST_LAST 2'h1
`define BTS_FIFO_DEPTH 2'h2
`define BTS_RD_LAT_LAST 1'h1
`define BTS_DIR_READ 1'b1
`endif

//--- rtl/bts_mem.sv
`include "bts_map.svh"
`default_nettype none
module bts_mem (
    // clock
    input wire logic i_clock,
    input wire logic i_ce,
    // request
    input wire bts_pkg::bts_mem_req_t i_req,
    // answer
    output logic [`BTS_DATA_W-1:0] o_rdata
);
    logic [`BTS_DATA_W-1:0] array [0:(1<<(`BTS_ADDR_W+1))-1];
    logic [`BTS_DATA_W-1:0] bit_we;

    // lane enables widened to one enable per data bit
    function automatic logic [`BTS_DATA_W-1:0] lane_bits(input logic [`BTS_LANES-1:0] lanes);
        logic [`BTS_DATA_W-1:0] bits;
        bits = '0;
        for (int b = 0; b < `BTS_DATA_W; b++) begin
            bits[b] = lanes[b / `BTS_LANE_W];
        end
        return bits;
    endfunction

    assign bit_we = lane_bits(i_req.lane_we);

    always_ff @(posedge i_clock) begin
        if (i_ce && i_req.we) begin
            // masked lanes keep their old contents
            array[i_req.addr] <= (array[i_req.addr] & ~bit_we) | (i_req.wdata & bit_we);
        end
        if (i_ce && i_req.re) begin
            o_rdata <= array[i_req.addr];
        end
    end
endmodule // bts_mem
`default_nettype wire

//--- rtl/bts_pkg.sv
`include "bts_map.svh"
`default_nettype none
package bts_pkg;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic clk_p;
        logic clk_n;
        logic load_strobe_n;
        logic dir_read;
        logic [`BTS_ADDR_W-1:0] addr;
        logic [`BTS_DATA_W-1:0] dq;
        logic [`BTS_LANES-1:0] byte_write_mask_n;
    } bts_pins_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [`BTS_LANES-1:0] lane_we;
        logic [`BTS_ADDR_W:0] addr;
        logic [`BTS_DATA_W-1:0] wdata;
    } bts_mem_req_t;

    // ****************************************
    // states
    // ****************************************
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_LAT = 2'b01,
        RD_WORD0 = 2'b10,
        RD_WORD1 = 2'b11
    } bts_rd_state_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_WORD0 = 2'b01,
        WR_WORD1 = 2'b10
    } bts_wr_state_t;

    // word address of one beat of a burst
    function automatic logic [`BTS_ADDR_W:0] burst_addr(
        input logic [`BTS_ADDR_W-1:0] base,
        input logic idx
    );
        return {base, idx};
    endfunction
endpackage
`default_nettype wire

//--- rtl/bts_port.sv
`include "bts_map.svh"
`default_nettype none
// Summary of operation
// RL1 - write words captured on positive and negative input clock rising edges
// RL2 - read words driven on both clock rising edges, one word per edge
// RL3 - data drivers released whenever no read word is being driven
// RL4 - controller pulls load strobe low on a positive edge with address, direction
// RL5 - every read or write moves exactly two words for one loaded address
// RL6 - data bus width is 8, 9, 18 or 36 bits
// RL7 - direction high during load requests read, low requests write
// RL8 - address sampled only on positive edge with load active, else ignored
// RL9 - active-low lane masks sampled with each write word; masked lanes untouched
// RL10 - output valid flag high exactly while read data driven, echo-aligned
// RL11 - first read word two positive edges after load, second half-cycle later
module bts_port (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // input clock pair
    input wire logic i_k,
    input wire logic i_k_n,
    // command pins
    input wire logic i_load_strobe_n,
    input wire logic i_dir_read,
    input wire logic [`BTS_ADDR_W-1:0] i_addr,
    input wire logic [`BTS_LANES-1:0] i_byte_write_mask_n,
    // shared data bus
    input wire logic [`BTS_DATA_W-1:0] i_dq,
    output logic [`BTS_DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    // status pins
    output logic o_output_valid_flag,
    output logic o_output_echo_clock
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    bts_pkg::bts_pins_t pin_raw;
    bts_pkg::bts_pins_t pin_meta;
    bts_pkg::bts_pins_t pin_sync;
    logic k_prev;
    logic kn_prev;

    assign pin_raw = {i_k, i_k_n, i_load_strobe_n, i_dir_read, i_addr, i_dq,
                      i_byte_write_mask_n};

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
            k_prev <= 1'b0;
            kn_prev <= 1'b0;
        end else if (i_ce) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            k_prev <= pin_sync.clk_p;
            kn_prev <= pin_sync.clk_n;
        end
    end

    wire k_rise = pin_sync.clk_p & ~k_prev;
    wire kn_rise = pin_sync.clk_n & ~kn_prev;

    // ****************************************
    // command decode
    // ****************************************
    bts_pkg::bts_rd_state_t rd_state;
    bts_pkg::bts_rd_state_t next_rd_state;
    bts_pkg::bts_wr_state_t wr_state;
    bts_pkg::bts_wr_state_t next_wr_state;
    logic rd_lat_cnt;
    logic [`BTS_ADDR_W-1:0] rd_base;
    logic [`BTS_ADDR_W-1:0] wr_base;
    logic [1:0] rd_issue_cnt;
    logic rd_pending;

    // no overlap: a load during a write burst, or in RD_LAT or RD_WORD0 of a read, is dropped
    wire rd_free = (rd_state == bts_pkg::RD_IDLE) || (rd_state == bts_pkg::RD_WORD1);
    wire load_seen = k_rise & ~pin_sync.load_strobe_n; // see RL4
    wire load_ok = load_seen & rd_free & (wr_state == bts_pkg::WR_IDLE); // see RL8
    wire rd_load = load_ok & (pin_sync.dir_read == `BTS_DIR_READ); // see RL7
    wire wr_load = load_ok & (pin_sync.dir_read != `BTS_DIR_READ); // see RL7
    wire lat_done = (rd_state == bts_pkg::RD_LAT) & k_rise & (rd_lat_cnt == `BTS_RD_LAT_LAST);
    wire pop_word0 = lat_done; // see RL11
    wire pop_word1 = (rd_state == bts_pkg::RD_WORD0) & kn_rise; // see RL2
    wire rd_drive_next = (next_rd_state == bts_pkg::RD_WORD0) ||
                         (next_rd_state == bts_pkg::RD_WORD1);

    // ****************************************
    // read sequencer
    // ****************************************
    always_comb begin
        next_rd_state = rd_state;
        case (rd_state)
            bts_pkg::RD_IDLE: begin
                if (rd_load) begin
                    next_rd_state = bts_pkg::RD_LAT;
                end
            end
            bts_pkg::RD_LAT: begin
                if (lat_done) begin
                    next_rd_state = bts_pkg::RD_WORD0; // see RL11
                end
            end
            bts_pkg::RD_WORD0: begin
                if (kn_rise) begin
                    next_rd_state = bts_pkg::RD_WORD1; // see RL2
                end
            end
            bts_pkg::RD_WORD1: begin
                if (k_rise) begin
                    next_rd_state = rd_load ? bts_pkg::RD_LAT : bts_pkg::RD_IDLE;
                end
            end
            default: next_rd_state = bts_pkg::RD_IDLE;
        endcase
    end

    // ****************************************
    // write sequencer
    // ****************************************
    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            bts_pkg::WR_IDLE: begin
                if (wr_load) begin
                    next_wr_state = bts_pkg::WR_WORD0;
                end
            end
            bts_pkg::WR_WORD0: begin
                if (k_rise) begin
                    next_wr_state = bts_pkg::WR_WORD1; // see RL1
                end
            end
            bts_pkg::WR_WORD1: begin
                if (kn_rise) begin
                    next_wr_state = bts_pkg::WR_IDLE; // see RL1
                end
            end
            default: next_wr_state = bts_pkg::WR_IDLE;
        endcase
    end

    // ****************************************
    // memory port
    // ****************************************
    bts_pkg::bts_mem_req_t mem_req;
    logic [`BTS_DATA_W-1:0] mem_rdata;
    logic [1:0] fifo_count;

    wire wr_beat = ((wr_state == bts_pkg::WR_WORD0) & k_rise) |
                   ((wr_state == bts_pkg::WR_WORD1) & kn_rise); // see RL1
    // writes win the single port; a read issue just retries next cycle
    wire fifo_space = ({1'b0, fifo_count} + {2'b00, rd_pending}) < {1'b0, `BTS_FIFO_DEPTH};
    wire rd_issue = (rd_issue_cnt != 2'h0) & ~wr_beat & fifo_space;
    wire rd_idx = (rd_issue_cnt == `BTS_BURST_LAST);

    assign mem_req.we = wr_beat;
    assign mem_req.re = rd_issue;
    assign mem_req.lane_we = ~pin_sync.byte_write_mask_n; // see RL9
    assign mem_req.addr = wr_beat ?
        bts_pkg::burst_addr(wr_base, wr_state == bts_pkg::WR_WORD1) :
        bts_pkg::burst_addr(rd_base, rd_idx);
    assign mem_req.wdata = pin_sync.dq;

    bts_mem u_mem (
        .i_clock(i_clock),
        .i_ce(i_ce),
        .i_req(mem_req),
        .o_rdata(mem_rdata)
    );

    // ****************************************
    // two-entry read buffer
    // ****************************************
    logic [`BTS_DATA_W-1:0] fifo_mem [0:1];
    logic fifo_wr_ptr;
    logic fifo_rd_ptr;

    wire push_valid = rd_pending;
    wire push_ready = fifo_count != `BTS_FIFO_DEPTH;
    wire pop_valid = fifo_count != 2'h0;
    wire pop_ready = pop_word0 | pop_word1;
    wire push = push_valid & push_ready;
    wire pop = pop_valid & pop_ready;

    always_ff @(posedge i_clock) begin
        if (i_ce && push) begin
            fifo_mem[fifo_wr_ptr] <= mem_rdata;
        end
    end

    // ****************************************
    // state registers
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rd_state <= bts_pkg::RD_IDLE;
            wr_state <= bts_pkg::WR_IDLE;
            rd_lat_cnt <= 1'b0;
            rd_base <= '0;
            wr_base <= '0;
            rd_issue_cnt <= 2'h0;
            rd_pending <= 1'b0;
            fifo_count <= 2'h0;
            fifo_wr_ptr <= 1'b0;
            fifo_rd_ptr <= 1'b0;
        end else if (i_ce) begin
            rd_state <= next_rd_state;
            wr_state <= next_wr_state;
            rd_pending <= rd_issue;
            if (rd_load) begin
                rd_base <= pin_sync.addr; // see RL8
                rd_issue_cnt <= `BTS_BURST; // see RL5
                rd_lat_cnt <= 1'b0;
            end else begin
                if (rd_issue) begin
                    rd_issue_cnt <= rd_issue_cnt - 2'h1;
                end
                if (rd_state == bts_pkg::RD_LAT && k_rise) begin
                    rd_lat_cnt <= ~rd_lat_cnt;
                end
            end
            if (wr_load) begin
                wr_base <= pin_sync.addr; // see RL8
            end
            fifo_count <= fifo_count + {1'b0, push} - {1'b0, pop};
            fifo_wr_ptr <= fifo_wr_ptr ^ push;
            fifo_rd_ptr <= fifo_rd_ptr ^ pop;
        end
    end

    // ****************************************
    // pin outputs
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_dq <= '0;
            o_dq_oe <= 1'b0;
            o_output_valid_flag <= 1'b0;
            o_output_echo_clock <= 1'b0;
        end else if (i_ce) begin
            if (pop) begin
                o_dq <= fifo_mem[fifo_rd_ptr]; // see RL2
            end
            o_dq_oe <= rd_drive_next; // see RL3
            o_output_valid_flag <= rd_drive_next; // see RL10
            // echo toggles on the same cycle the data changes
            o_output_echo_clock <= pin_sync.clk_p; // see RL10
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    bus_width_a: assert property (`BTS_DATA_W == 8 || `BTS_DATA_W == 9 || // see RL6
        `BTS_DATA_W == 18 || `BTS_DATA_W == 36)
        else $error("unsupported data bus width");
    oe_release_a: assert property ((rd_state == bts_pkg::RD_IDLE || // see RL3
        rd_state == bts_pkg::RD_LAT) |-> !o_dq_oe)
        else $error("data bus driven outside a read");
    valid_tracks_a: assert property (o_output_valid_flag == o_dq_oe && // see RL10
        o_output_valid_flag == (rd_state == bts_pkg::RD_WORD0 || rd_state == bts_pkg::RD_WORD1))
        else $error("valid flag differs from bus drive");
    first_word_a: assert property (i_ce && lat_done |=> // see RL11
        rd_state == bts_pkg::RD_WORD0 && o_dq_oe)
        else $error("first read word not driven after latency");
    second_word_a: assert property (i_ce && pop_word1 |=> // see RL2
        rd_state == bts_pkg::RD_WORD1 && o_dq_oe && o_dq == $past(fifo_mem[fifo_rd_ptr]))
        else $error("second read word missing");
    word_ready_a: assert property (pop_ready |-> pop_valid) // see RL5
        else $error("read word not fetched in time");
    burst_issue_a: assert property (i_ce && rd_load |=> rd_issue_cnt == `BTS_BURST) // see RL5
        else $error("read burst not two words");
    write_beats_a: assert property (i_ce && wr_state == bts_pkg::WR_WORD1 && kn_rise // see RL1
        |-> mem_req.we && mem_req.addr == {wr_base, 1'b1})
        else $error("second write word not stored");
    write_mask_a: assert property (mem_req.we |-> // see RL9
        mem_req.lane_we == ~pin_sync.byte_write_mask_n)
        else $error("write lanes not from masks");
    addr_ignore_a: assert property (i_ce && !load_ok |=> // see RL8
        rd_base == $past(rd_base) && wr_base == $past(wr_base))
        else $error("address taken without a load");
endmodule // bts_port
`default_nettype wire

//--- verification/bts_ctrl_model.sv
`include "bts_map.svh"
`default_nettype none
// ****************************************
// controller model: free K pair, load, data
// ****************************************
module bts_ctrl_model (
    // clock
    input wire logic i_clock,
    // pins toward the port
    output bts_pkg::bts_pins_t o_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] phase = 4'h0;
    logic [15:0] periods = 16'h0;
    logic load_n = 1'b1;
    logic dir = 1'b0;
    logic [`BTS_ADDR_W-1:0] addr = 8'h00;
    logic [`BTS_DATA_W-1:0] dq = 18'h00000;
    logic [`BTS_LANES-1:0] mask = 2'h3;
    // k half period of 8 clocks keeps the port's buffer filled
    always @(posedge i_clock) begin
        phase <= #1 phase + 4'h1;
        if (phase == 4'hF) periods <= #1 periods + 16'h1;
    end
    assign o_pins = {~phase[3], phase[3], load_n, dir, addr, dq, mask};
    task automatic at_phase(input logic [3:0] p);
        @(posedge i_clock);
        while (phase !== p) @(posedge i_clock);
        #1;
    endtask
    // pins move a quarter period away from any k edge
    task automatic burst(input logic rd, input logic [`BTS_ADDR_W-1:0] a,
        input logic [`BTS_DATA_W-1:0] w0, w1, input logic [1:0] m0, m1, input logic full);
        at_phase(4'hC);
        load_n = 1'b0;
        dir = rd;
        addr = a;
        at_phase(4'h4);
        load_n = 1'b1;
        dir = ~rd;
        addr = ~a;
        // word0 rides the k rise after the load edge, word1 the k_n rise after it
        if (!rd) begin
            at_phase(4'hC);
            dq = w0;
            mask = m0;
            at_phase(4'h4);
            dq = w1;
            mask = m1;
            at_phase(4'hC);
        end
        // released bus shows the inverse, never a held value
        dq = ~dq;
        mask = ~mask;
        if (rd && full) begin
            at_phase(4'hC);
            at_phase(4'hC);
        end
    endtask
endmodule // bts_ctrl_model
`default_nettype wire

//--- verification/burst_two_sram_data_port_tb.sv
`include "bts_map.svh"
`default_nettype none
module burst_two_sram_data_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    bts_pkg::bts_pins_t pins;
    logic [`BTS_DATA_W-1:0] o_dq;
    logic [`BTS_DATA_W-1:0] dq_wire;
    logic oe, valid, echo;
    logic valid_q = 1'b0;
    logic echo_q = 1'b0;
    logic [`BTS_DATA_W-1:0] mem [0:511];
    logic [`BTS_DATA_W-1:0] exp_q [$];
    logic [15:0] due_q [$];
    logic [`BTS_ADDR_W-1:0] addrs [0:7];
    integer num_errors = 0;
    integer check_count = 0;
    integer seed = 20160;
    integer cycles = 0;
    integer i;
    initial forever #5 i_clock = ~i_clock;
    bts_ctrl_model u_ctrl (.i_clock(i_clock), .o_pins(pins));
    assign dq_wire = oe ? o_dq : pins.dq;
    bts_port uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_k(pins.clk_p),
        .i_k_n(pins.clk_n), .i_load_strobe_n(pins.load_strobe_n), .i_dir_read(pins.dir_read),
        .i_addr(pins.addr), .i_byte_write_mask_n(pins.byte_write_mask_n), .i_dq(dq_wire),
        .o_dq(o_dq), .o_dq_oe(oe), .o_output_valid_flag(valid), .o_output_echo_clock(echo));
    // ****************************************
    // checking
    // ****************************************
    task automatic stop_test();
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [`BTS_DATA_W-1:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // echo toggles with every new word while valid
    always @(posedge i_clock) begin
        valid_q <= valid;
        echo_q <= echo;
        if (i_rst_n) begin
            check("oe", 18'(oe), 18'(valid));
            if (valid === 1'b1 && (!valid_q || echo !== echo_q)) begin
                if (exp_q.size() == 0) check("extra word", 18'h1, 18'h0);
                else check("read word", o_dq, exp_q.pop_front());
            end
            if (valid === 1'b1 && !valid_q)
                check("latency", 18'(u_ctrl.periods), 18'(due_q.pop_front()));
        end
    end
    // ****************************************
    // stimulus
    // ****************************************
    task automatic do_write(input logic [`BTS_ADDR_W-1:0] a,
        input logic [`BTS_DATA_W-1:0] w0, w1, input logic [1:0] m0, m1);
        logic [`BTS_DATA_W-1:0] o0, o1;
        o0 = mem[{a, 1'b0}];
        o1 = mem[{a, 1'b1}];
        mem[{a, 1'b0}] = {m0[1] ? o0[17:9] : w0[17:9], m0[0] ? o0[8:0] : w0[8:0]};
        mem[{a, 1'b1}] = {m1[1] ? o1[17:9] : w1[17:9], m1[0] ? o1[8:0] : w1[8:0]};
        u_ctrl.burst(1'b0, a, w0, w1, m0, m1, 1'b1);
    endtask
    task automatic do_read(input logic [`BTS_ADDR_W-1:0] a, input logic full);
        // let the model's phase settle before reading it
        #1;
        exp_q.push_back(mem[{a, 1'b0}]);
        exp_q.push_back(mem[{a, 1'b1}]);
        due_q.push_back(u_ctrl.periods + ((u_ctrl.phase > 4'hC) ? 16'h4 : 16'h3));
        u_ctrl.burst(1'b1, a, 18'h0, 18'h0, 2'h0, 2'h0, full);
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
        repeat (4) @(posedge i_clock);
        #1;
        for (i = 0; i < 8; i++) begin
            addrs[i] = (i == 7) ? 8'hFF : 8'(i * 37);
            do_write(addrs[i], 18'($random(seed)), 18'($random(seed)), 2'h0, 2'h0);
        end
        // random lane masks, all-masked included
        for (i = 0; i < 16; i++)
            do_write(addrs[3'($random(seed))], 18'($random(seed)), 18'($random(seed)),
                2'($random(seed)), 2'($random(seed)));
        for (i = 0; i < 8; i++) do_read(addrs[i], 1'b1);
        // second load during a busy read is dropped
        do_read(addrs[3], 1'b0);
        u_ctrl.burst(1'b1, addrs[5], 18'h0, 18'h0, 2'h0, 2'h0, 1'b1);
        do_write(addrs[0], 18'h3FFFF, 18'h00000, 2'h1, 2'h2);
        do_read(addrs[0], 1'b1);
        repeat (60) @(posedge i_clock);
        check("words left", 18'(exp_q.size()), 18'h0);
        stop_test();
    end
endmodule // burst_two_sram_data_port_tb
`default_nettype wire
